/* File: verilog/ssw_top.v */
// Station status word encoder: assembles and serves the 16-bit status word
`timescale 1ns/1ps
`include "ssw_defs.vh"

module ssw_top #(
    parameter CNT_W = 6
) (
    core_clk,
    resetn,
    unit_active,
    sim_active,
    param_busy,
    fault_src,
    fault_is_module,
    fault_count,
    fault_slot,
    supply_map,
    xfer_enable,
    cyc_tick,
    rd_req,
    status_word_q,
    rd_data_q,
    rd_ack_q,
    cyc_word_q,
    cyc_valid_q
);
    input  wire                   core_clk;
    input  wire                   resetn;
    input  wire                   unit_active;
    input  wire                   sim_active;
    input  wire                   param_busy;
    input  wire [`SSW_SRC_W-1:0]  fault_src;
    input  wire                   fault_is_module;
    input  wire [CNT_W-1:0]       fault_count;
    input  wire [`SSW_FIELD_W-1:0] fault_slot;
    input  wire [`SSW_FIELD_W-1:0] supply_map;
    input  wire                   xfer_enable;
    input  wire                   cyc_tick;
    input  wire                   rd_req;
    output reg  [`SSW_WORD_W-1:0] status_word_q;
    output reg  [`SSW_WORD_W-1:0] rd_data_q;
    output reg                    rd_ack_q;
    output reg  [`SSW_WORD_W-1:0] cyc_word_q;
    output reg                    cyc_valid_q;

    // ------------------------------------------------------------------
    // Fault priority
    // ------------------------------------------------------------------
    wire [`SSW_CODE_W-1:0] top_code;
    wire                   any_fault;

    // Source index equals code: 1-3 io RAM/reg/flash, 4 int, 5 cmd,
    // 6 module, 7 supply, 8/9 main RAM/flash, A wdog, B-E redundancy
    ssw_prio u_prio (
        .fault_src (fault_src),
        .err_code  (top_code),
        .any_fault (any_fault)
    );

    // ------------------------------------------------------------------
    // Count saturation
    // ------------------------------------------------------------------
    // A wide counter must not wrap into a small, misleading number
    function [`SSW_FIELD_W-1:0] sat_count;
        input [CNT_W-1:0] cnt;
        begin
            if (|(cnt >> `SSW_FIELD_W)) begin
                sat_count = `SSW_FIELD_MAX;
            end else begin
                sat_count = cnt[`SSW_FIELD_W-1:0];
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // Word assembly
    // ------------------------------------------------------------------
    reg  [`SSW_WORD_W-1:0]  status_word_d;
    reg  [`SSW_FIELD_W-1:0] cnt_sat;
    reg  [`SSW_FIELD_W-1:0] low_field;
    reg                     only_supply;
    reg                     multi;
    reg  [`SSW_CODE_W-1:0]  shown_code;

    always @* begin
        cnt_sat     = sat_count(fault_count);
        only_supply = any_fault &&
                      ((fault_src & `SSW_SRC_VALID) == `SSW_SRC_SUPPLY);
        // Supply-only faults keep bit 7 clear so the map can be read
        multi       = any_fault && !only_supply &&
                      (cnt_sat > `SSW_CNT_ONE);
        shown_code  = top_code;
        if (shown_code == `SSW_EC_RESERVED) begin
            shown_code = `SSW_EC_NONE;
        end
        if (!any_fault) begin
            low_field = `SSW_FIELD_ZERO;
        end else if (only_supply) begin
            low_field = supply_map;
        end else if (multi) begin
            low_field = cnt_sat;
        end else begin
            low_field = fault_slot;
        end
        status_word_d = `SSW_WORD_RST;
        status_word_d[`SSW_BIT_ACTIVE] = unit_active;
        status_word_d[`SSW_BIT_SIM]    = sim_active;
        status_word_d[`SSW_BIT_FAULT]  = any_fault;
        status_word_d[`SSW_BIT_MODULE] = any_fault &&
                                         fault_is_module;
        status_word_d[`SSW_CODE_HI:`SSW_CODE_LO] = shown_code;
        status_word_d[`SSW_BIT_MULTI]  = multi;
        status_word_d[`SSW_BIT_PARAM]  = param_busy;
        status_word_d[`SSW_FIELD_HI:`SSW_FIELD_LO] = low_field;
    end

    // ------------------------------------------------------------------
    // Live word
    // ------------------------------------------------------------------
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            status_word_q <= `SSW_WORD_RST;
        end else begin
            status_word_q <= status_word_d;
        end
    end

    // ------------------------------------------------------------------
    // Acyclic read
    // ------------------------------------------------------------------
    // Snapshot keeps both bytes coherent for a byte-wise reader
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rd_data_q <= `SSW_WORD_RST;
            rd_ack_q  <= 1'b0;
        end else begin
            rd_ack_q <= rd_req;
            if (rd_req) begin
                rd_data_q <= {status_word_q[`SSW_UPPER_HI:`SSW_UPPER_LO],
                              status_word_q[`SSW_LOWER_HI:`SSW_LOWER_LO]};
            end
        end
    end

    // ------------------------------------------------------------------
    // Cyclic exchange
    // ------------------------------------------------------------------
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cyc_word_q  <= `SSW_WORD_RST;
            cyc_valid_q <= 1'b0;
        end else begin
            cyc_valid_q <= cyc_tick && xfer_enable;
            if (cyc_tick && xfer_enable) begin
                cyc_word_q <= status_word_q;
            end
        end
    end

endmodule

/* File: inc/ssw_defs.vh */
// Bit layout, error codes and field constants of the station status word
`ifndef SSW_DEFS_VH
`define SSW_DEFS_VH

// Word geometry
`define SSW_WORD_W        16
`define SSW_FIELD_W       6
`define SSW_CODE_W        4
`define SSW_SRC_W         16

// Bit positions
`define SSW_BIT_ACTIVE    15
`define SSW_BIT_SIM       14
`define SSW_BIT_FAULT     13
`define SSW_BIT_MODULE    12
`define SSW_CODE_HI       11
`define SSW_CODE_LO       8
`define SSW_BIT_MULTI     7
`define SSW_BIT_PARAM     6
`define SSW_FIELD_HI      5
`define SSW_FIELD_LO      0
`define SSW_UPPER_HI      15
`define SSW_UPPER_LO      8
`define SSW_LOWER_HI      7
`define SSW_LOWER_LO      0

// Error codes
`define SSW_EC_NONE       4'h0
`define SSW_EC_IO_RAM     4'h1
`define SSW_EC_IO_REG     4'h2
`define SSW_EC_IO_FLASH   4'h3
`define SSW_EC_IO_INT     4'h4
`define SSW_EC_IO_CMD     4'h5
`define SSW_EC_MODULE     4'h6
`define SSW_EC_SUPPLY     4'h7
`define SSW_EC_MP_RAM     4'h8
`define SSW_EC_MP_FLASH   4'h9
`define SSW_EC_MP_WDOG    4'ha
`define SSW_EC_RED_ARITH  4'hb
`define SSW_EC_RED_NOPART 4'hc
`define SSW_EC_RED_LINK   4'hd
`define SSW_EC_RED_PARAM  4'he
`define SSW_EC_RESERVED   4'hf

// Source vector handling
`define SSW_SRC_VALID     16'h7ffe
`define SSW_SRC_SUPPLY    16'h0080
`define SSW_SRC_NONE      16'h0000

// Field constants
`define SSW_FIELD_ZERO    6'h00
`define SSW_FIELD_MAX     6'h3f
`define SSW_CNT_ONE       6'h01
`define SSW_WORD_RST      16'h0000

`endif

/* File: verilog/ssw_prio.v */
// Priority encoder picking the error code of the most urgent fault source
`timescale 1ns/1ps
`include "ssw_defs.vh"

module ssw_prio (
    fault_src,
    err_code,
    any_fault
);
    input  wire [`SSW_SRC_W-1:0]  fault_src;
    output reg  [`SSW_CODE_W-1:0] err_code;
    output reg                    any_fault;

    reg [`SSW_SRC_W-1:0] valid_src;
    integer              i;

    // ------------------------------------------------------------------
    // Encoder
    // ------------------------------------------------------------------
    // Lowest code wins; walk down so the smallest index lands last
    always @* begin
        valid_src = fault_src & `SSW_SRC_VALID;
        err_code  = `SSW_EC_NONE;
        any_fault = |valid_src;
        for (i = `SSW_SRC_W - 1; i > 0; i = i - 1) begin
            if (valid_src[i]) begin
                err_code = i[`SSW_CODE_W-1:0];
            end
        end
    end

endmodule

/* File: verif/ssw_checker.sv */
// Concurrent checks on the station status word encoder ports
`timescale 1ns/1ps
`include "ssw_defs.vh"
module ssw_checker (
    input logic        core_clk,
    input logic        resetn,
    input logic        unit_active,
    input logic        sim_active,
    input logic        param_busy,
    input logic [15:0] fault_src,
    input logic        fault_is_module,
    input logic        xfer_enable,
    input logic        cyc_tick,
    input logic        rd_req,
    input logic [15:0] status_word_q,
    input logic [15:0] rd_data_q,
    input logic        rd_ack_q,
    input logic [15:0] cyc_word_q,
    input logic        cyc_valid_q
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Word is one edge behind its inputs, so skip the edge after reset
    sequence s_rd; rd_req; endsequence
    sequence s_rd_ans;
        rd_ack_q && rd_data_q == $past(status_word_q);
    endsequence
    property p_rd; s_rd |=> s_rd_ans; endproperty
    a_rd: assert property (p_rd) else $error("read answer wrong");
    property p_no_ack; !rd_req |=> !rd_ack_q; endproperty
    a_no_ack: assert property (p_no_ack) else $error("stray ack");
    property p_cyc; cyc_tick && xfer_enable |=>
        cyc_valid_q && cyc_word_q == $past(status_word_q); endproperty
    a_cyc: assert property (p_cyc) else $error("cyclic copy wrong");
    property p_cyc_off; !(cyc_tick && xfer_enable) |=>
        !cyc_valid_q && $stable(cyc_word_q); endproperty
    a_cyc_off: assert property (p_cyc_off) else $error("cyclic leak");
    property p_flags; $past(resetn) |-> {status_word_q[15:14],
        status_word_q[6]} == {$past(unit_active), $past(sim_active),
        $past(param_busy)}; endproperty
    a_flags: assert property (p_flags) else $error("flag bits");
    property p_flt; $past(resetn) |-> status_word_q[13] ==
        |($past(fault_src) & `SSW_SRC_VALID); endproperty
    a_flt: assert property (p_flt) else $error("fault bit");
    property p_mod; $past(resetn) |-> status_word_q[12] ==
        ($past(fault_is_module) && status_word_q[13]); endproperty
    a_mod: assert property (p_mod) else $error("module bit");
    property p_code; status_word_q[11:8] != 4'hf &&
        (status_word_q[13] || status_word_q[11:8] == 4'h0); endproperty
    a_code: assert property (p_code) else $error("code field");
    property p_multi; status_word_q[7] |->
        status_word_q[13] && status_word_q[5:0] > 6'h01; endproperty
    a_multi: assert property (p_multi) else $error("multi bit");
endmodule

bind ssw_top ssw_checker u_chk (.core_clk, .resetn, .unit_active,
    .sim_active, .param_busy, .fault_src, .fault_is_module, .xfer_enable,
    .cyc_tick, .rd_req, .status_word_q, .rd_data_q, .rd_ack_q,
    .cyc_word_q, .cyc_valid_q);

/* File: verif/ssw_master.sv */
// Fieldbus master model issuing reads and cyclic exchange instants
`timescale 1ns/1ps
module ssw_master (
    input  wire core_clk,
    input  wire rd_go,
    input  wire tick_go,
    output reg  rd_req,
    output reg  cyc_tick
);
    initial {rd_req, cyc_tick} = 2'b00;
    // Off the sampling edge, so the unit never sees a moving request
    always @(negedge core_clk) begin
        rd_req <= rd_go;
        cyc_tick <= tick_go;
    end
endmodule

/* File: verif/ssw_tb_top.sv */
// Self-checking bench of the station status word encoder
`timescale 1ns/1ps
`include "ssw_defs.vh"
module ssw_tb_top;
    reg         core_clk, resetn, unit_active, sim_active, param_busy;
    reg         fault_is_module, xfer_enable, rd_go, tick_go;
    reg  [15:0] fault_src, w;
    reg  [5:0]  fault_count, fault_slot, supply_map;
    wire        rd_req, cyc_tick, rd_ack_q, cyc_valid_q;
    wire [15:0] status_word_q, rd_data_q, cyc_word_q;
    reg  [15:0] rd_exp[$], cyc_exp[$];
    integer     seed, error_cnt, checks_done, i, n;

    ssw_top u_dut (.core_clk, .resetn, .unit_active, .sim_active,
        .param_busy, .fault_src, .fault_is_module, .fault_count,
        .fault_slot, .supply_map, .xfer_enable, .cyc_tick, .rd_req,
        .status_word_q, .rd_data_q, .rd_ack_q, .cyc_word_q, .cyc_valid_q);
    ssw_master u_mst (.core_clk, .rd_go, .tick_go, .rd_req, .cyc_tick);

    // Lowest code number wins; bits 0 and 15 carry no code
    function [15:0] exp_word;
        input [15:0] s;
        reg   [15:0] v;
        integer      j;
        begin
            v = s & `SSW_SRC_VALID;
            exp_word = {unit_active, sim_active, v != 0,
                fault_is_module && v != 0, 12'h000};
            exp_word[6] = param_busy;
            for (j = 14; j > 0; j = j - 1)
                if (v[j])
                    exp_word[11:8] = j[3:0];
            if (v == `SSW_SRC_SUPPLY)
                exp_word[5:0] = supply_map;
            else if (v != 0 && fault_count > 1)
                exp_word[7:0] = {1'b1, param_busy, fault_count};
            else if (v != 0)
                exp_word[5:0] = fault_slot;
        end
    endfunction

    task cmp;
        input [15:0] got, exp;
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("ERROR %0t word %h expected %h", $time, got, exp);
            end
        end
    endtask

    task report_and_stop;
        begin
            if (error_cnt == 0 && checks_done > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // A missing note becomes unknown and so always mismatches
    always @(negedge core_clk) begin
        if (rd_ack_q === 1'b1 && rd_exp.size() == 0)
            rd_exp.push_back(16'hxxxx);
        if (cyc_valid_q === 1'b1 && cyc_exp.size() == 0)
            cyc_exp.push_back(16'hxxxx);
        if (rd_ack_q === 1'b1)
            cmp(rd_data_q, rd_exp.pop_front());
        if (cyc_valid_q === 1'b1)
            cmp(cyc_word_q, cyc_exp.pop_front());
    end

    initial begin
        seed = 32'h31775b2d;
        {resetn, unit_active, sim_active, param_busy, fault_is_module} = 0;
        {xfer_enable, rd_go, tick_go, fault_src, fault_count} = 0;
        {fault_slot, supply_map, error_cnt, checks_done} = 0;
        repeat (3) @(negedge core_clk);
        resetn = 1'b1;
        for (i = 0; i < 48; i = i + 1) begin
            @(negedge core_clk);
            n = $random(seed);
            {unit_active, sim_active, param_busy, fault_is_module} = n[3:0];
            {xfer_enable, fault_count, fault_slot, supply_map} = n[31:13];
            fault_src = $random(seed) & $random(seed);
            if (i < 16)
                fault_src = 16'h0001 << i;
            else if (i < 20)
                fault_src = 16'h0080 | {i[0], 14'h0000, i[1]};
            w = exp_word(fault_src);
            @(negedge core_clk);
            rd_go <= 1'b1;
            tick_go <= 1'b1;
            rd_exp.push_back(w);
            if (xfer_enable)
                cyc_exp.push_back(w);
            if (n[4]) begin
                @(negedge core_clk);
                rd_exp.push_back(w);
                if (xfer_enable)
                    cyc_exp.push_back(w);
            end
            @(negedge core_clk);
            rd_go <= 1'b0;
            tick_go <= 1'b0;
            repeat (2) @(negedge core_clk);
        end
        cmp(16'(rd_exp.size() + cyc_exp.size()), 16'h0000);
        report_and_stop;
    end

    initial begin
        #(100 * 5000);
        error_cnt = error_cnt + 1;
        report_and_stop;
    end
endmodule
